// >>> hw/thermal_throttle_pkg.sv
// package: register fields, reset values, timing and types for the thermal throttle block
package thermal_throttle_pkg;
	localparam int unsigned CLK_FREQ_HZ = 100_000_000;
	localparam int unsigned MIN_ENGAGE_US = 1000;
	localparam int unsigned MIN_ENGAGE_CYCLES = (MIN_ENGAGE_US * (CLK_FREQ_HZ / 1_000_000));
	localparam int unsigned MSR_ADDR_W = 2;
	localparam logic [1:0] ADDR_THERMAL_STATUS = 2'h0;
	localparam logic [1:0] ADDR_THERMAL_INT_CTRL = 2'h1;
	localparam logic [1:0] ADDR_CLOCK_DUTY_CTRL = 2'h2;
	localparam logic [1:0] ADDR_MISC_FEATURE_EN = 2'h3;
	localparam int unsigned STAT_CUR_BIT = 0;
	localparam int unsigned STAT_LOG_BIT = 1;
	localparam int unsigned INT_HIGH_EN_BIT = 0;
	localparam int unsigned INT_LOW_EN_BIT = 1;
	localparam int unsigned DUTY_EXT_BIT = 0;
	localparam int unsigned DUTY_SEL_LSB = 1;
	localparam int unsigned DUTY_EN_BIT = 4;
	localparam int unsigned MISC_DUTY_THROTTLE_BIT = 3;
	localparam int unsigned MISC_FV_THROTTLE_BIT = 13;
	localparam logic [4:0] CLOCK_DUTY_RESET = 5'h02;
	localparam logic [1:0] INT_CTRL_RESET = 2'h0;
	localparam logic [2:0] DUTY_CODE_RESERVED = 3'h0;
	localparam logic [3:0] THROTTLE_DUTY_SLOTS = 4'h8;
	typedef struct packed {
		logic wr;
		logic [1:0] addr;
		logic [63:0] wdata;
	} msr_req_t;
	typedef struct packed {
		logic valid;
		logic [15:0] target;
	} perf_req_t;
	typedef enum logic [1:0] {
		TCC_IDLE = 2'b00,
		TCC_MIN_HOLD = 2'b01,
		TCC_HYST = 2'b10
	} tcc_state_t;
endpackage : thermal_throttle_pkg

// >>> hw/stop_clock_gate.sv
// stop-clock window: passes the clock for a selected number of slots per window
`timescale 1ns/1ps
`default_nettype none
module stop_clock_gate
	import thermal_throttle_pkg::*;
#(
	parameter int unsigned SLOT_W = 4
)
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic active_in,
	input wire logic ext_mode_in,
	input wire logic [SLOT_W-1:0] pass_slots_in,
	output logic clk_pass_out,
	output logic window_end_out
);
	logic [SLOT_W-1:0] slot_reg;
	logic [SLOT_W-1:0] slot_next;
	wire logic [SLOT_W-1:0] last_slot;
	// the window is 8 slots normally and 16 in extended mode
	assign last_slot = ext_mode_in ? {SLOT_W{1'b1}} : SLOT_W'(7);
	assign slot_next = (slot_reg == last_slot) ? '0 : slot_reg + SLOT_W'(1);
	// duty means clock reaching the core, not waveform ratio
	assign clk_pass_out = !active_in || (slot_reg < pass_slots_in);
	assign window_end_out = !active_in || (slot_reg == last_slot);
	// counter idles at zero so a fresh window always starts at its first slot
	always_ff @(posedge clk_in)
	begin
		if (reset_in || !active_in)
			slot_reg <= '0;
		else
			slot_reg <= slot_next;
	end
endmodule : stop_clock_gate
`default_nettype wire

// >>> hw/thermal_throttle_clock_modulation.sv
// thermal throttle and on-demand clock modulation controller for one core
// Function
// - duty-cycle throttling lets performance changes start while the circuit is engaged.
// - frequency/voltage throttling holds performance changes until the circuit disengages.
// - status bit 0 reads one while tripped and throttling, else zero.
// - status bit 1 is a sticky trip log, software clears, reset clears.
// - throttling stays engaged at least about one millisecond after a trip.
// - after that, release only once the hysteresis-qualified cool signal arrives.
// - interrupts are held during stop-clock slots and delivered later, none lost.
// - high enable bit 0 requests interrupt on each rising trip.
// - low enable bit 1 requests interrupt on each falling trip.
// - interrupt passes a maskable vector entry; enables clear, entry masked at reset.
// - time-stamp counter counts every unmodulated clock.
// - adaptive throttling picks target by whether the current point cooled the core; here the adaptive low target is never applied.
// - each core has its own trip; adaptive trip in either moves both cores.
// - trip threshold is fixed at manufacture, no software field changes it.
// - duty control bit 4 enables software clock modulation, only once it is set in every thread.
// - duty select bits 3:1 act only while modulation enable is set.
// - 3-bit code n gives n eighths; code zero is reserved.
// - when tripped with duty throttling on and frequency/voltage throttling off, throttle duty overrides software duty.
// - per-thread duty registers; core uses lowest, or highest in legacy option.
// - each core applies its own duty independently of other cores.
// - with the extension, bit 0 joins bits 3:1 for sixteenth steps.
// - without the extension, bit 0 of duty control is reserved.
// - duty is the fraction of time the clock reaches the core.
// - misc enable bit 3 turns on duty throttling; cleared at reset.
// - misc enable bit 13 turns on frequency/voltage throttling.
// - frequency/voltage target comes from throttle target bits 15:0.
`timescale 1ns/1ps
`default_nettype none
module thermal_throttle_clock_modulation
	import thermal_throttle_pkg::*;
#(
	parameter int unsigned THREADS = 2,
	parameter int unsigned MIN_ENGAGE = MIN_ENGAGE_CYCLES,
	parameter bit EXT_SUPPORTED = 1'b1,
	parameter bit LEGACY_HIGHEST = 1'b0
)
(
	input wire logic clk_in,
	input wire logic reset_in,
	// register access, one request port per logical thread
	input wire msr_req_t [THREADS-1:0] msr_req_in,
	output logic [THREADS-1:0][63:0] msr_rdata_out,
	// factory-set sensor trip and its hysteresis-qualified cool indication
	input wire logic sensor_trip_in,
	input wire logic sensor_cool_in,
	input wire logic peer_core_trip_in,
	input wire logic adaptive_en_in,
	input wire logic [15:0] throttle_target_in,
	input wire logic [15:0] adaptive_low_target_in,
	input wire perf_req_t perf_req_in,
	input wire logic lvt_mask_in,
	input wire logic irq_pending_in,
	output logic irq_deliver_out,
	output logic thermal_irq_out,
	output logic core_clk_en_out,
	output logic adaptive_peer_req_out,
	output perf_req_t perf_apply_out,
	output logic [63:0] tsc_out
);
	localparam int unsigned CNT_W = $clog2(MIN_ENGAGE + 1);
	tcc_state_t state_reg, state_next;
	logic [CNT_W-1:0] hold_cnt_reg;
	logic [CNT_W-1:0] hold_cnt_next;
	logic log_reg;
	logic trip_prev_reg;
	logic [1:0] int_en_reg;
	logic [THREADS-1:0][4:0] duty_ctrl_reg;
	logic duty_throttle_en_reg;
	logic fv_throttle_en_reg;
	logic perf_held_reg;
	logic [15:0] perf_held_target_reg;
	logic perf_valid_reg;
	logic [15:0] perf_target_reg;
	logic [15:0] last_target_reg;
	wire logic irq_hold;
	logic [63:0] tsc_reg;
	logic [3:0] gate_slots;
	logic gate_pass;
	logic gate_window_end;
	wire logic tcc_engaged;
	wire logic tripped_any;
	wire logic rise_evt;
	wire logic fall_evt;
	wire logic [THREADS-1:0] wr_status;
	wire logic [THREADS-1:0] wr_int;
	wire logic [THREADS-1:0] wr_duty;
	wire logic [THREADS-1:0] wr_misc;
	wire logic log_clear;
	wire logic [THREADS-1:0][3:0] thread_slots;
	wire logic [THREADS-1:0] thread_on;
	wire logic sw_mod_on;
	wire logic throttle_duty_on;
	wire logic fv_engaged;
	wire logic [15:0] fv_target;
	wire logic [CNT_W-1:0] engage_last;
	// adaptive mode lets a peer trip throttle this core too
	assign tripped_any = sensor_trip_in || (adaptive_en_in && peer_core_trip_in);
	assign adaptive_peer_req_out = adaptive_en_in && sensor_trip_in;
	assign tcc_engaged = (state_reg != TCC_IDLE);
	assign engage_last = CNT_W'(MIN_ENGAGE - 1);
	assign rise_evt = sensor_trip_in && !trip_prev_reg;
	assign fall_evt = !sensor_trip_in && trip_prev_reg;
	// engage on trip, hold the minimum time, then wait for cool with hysteresis
	always_comb
	begin
		state_next = state_reg;
		hold_cnt_next = hold_cnt_reg;
		case (state_reg)
			TCC_IDLE:
			begin
				hold_cnt_next = '0;
				if (tripped_any)
					state_next = TCC_MIN_HOLD;
			end
			TCC_MIN_HOLD:
			begin
				hold_cnt_next = hold_cnt_reg + CNT_W'(1);
				if (hold_cnt_reg == engage_last)
					state_next = TCC_HYST;
			end
			TCC_HYST:
			begin
				hold_cnt_next = '0;
				if (sensor_cool_in && !tripped_any)
					state_next = TCC_IDLE;
			end
			default:
			begin
				state_next = TCC_IDLE;
				hold_cnt_next = '0;
			end
		endcase
	end
	// register decode per thread; status, interrupt and misc are core-wide
	genvar t;
	generate
		for (t = 0; t < THREADS; t++)
		begin : g_thread
			assign wr_status[t] = msr_req_in[t].wr && msr_req_in[t].addr == ADDR_THERMAL_STATUS;
			assign wr_int[t] = msr_req_in[t].wr && msr_req_in[t].addr == ADDR_THERMAL_INT_CTRL;
			assign wr_duty[t] = msr_req_in[t].wr && msr_req_in[t].addr == ADDR_CLOCK_DUTY_CTRL;
			assign wr_misc[t] = msr_req_in[t].wr && msr_req_in[t].addr == ADDR_MISC_FEATURE_EN;
			assign thread_on[t] = duty_ctrl_reg[t][DUTY_EN_BIT];
			// 3-bit code scaled to sixteenths; bit 0 joins only with the extension
			assign thread_slots[t] = (EXT_SUPPORTED && duty_ctrl_reg[t][DUTY_EXT_BIT]) ?
				duty_ctrl_reg[t][3:0] : {duty_ctrl_reg[t][3:1], 1'b0};
			always_comb
			begin
				msr_rdata_out[t] = '0;
				case (msr_req_in[t].addr)
					ADDR_THERMAL_STATUS:
					begin
						msr_rdata_out[t][STAT_CUR_BIT] = tcc_engaged && sensor_trip_in;
						msr_rdata_out[t][STAT_LOG_BIT] = log_reg;
					end
					ADDR_THERMAL_INT_CTRL: msr_rdata_out[t][1:0] = int_en_reg;
					ADDR_CLOCK_DUTY_CTRL: msr_rdata_out[t][4:0] = duty_ctrl_reg[t];
					ADDR_MISC_FEATURE_EN:
					begin
						msr_rdata_out[t][MISC_DUTY_THROTTLE_BIT] = duty_throttle_en_reg;
						msr_rdata_out[t][MISC_FV_THROTTLE_BIT] = fv_throttle_en_reg;
					end
					default: msr_rdata_out[t] = '0;
				endcase
			end
			// duty control is per thread
			always_ff @(posedge clk_in)
			begin
				if (reset_in)
					duty_ctrl_reg[t] <= CLOCK_DUTY_RESET;
				else if (wr_duty[t])
					duty_ctrl_reg[t] <= {msr_req_in[t].wdata[4:1],
						EXT_SUPPORTED ? msr_req_in[t].wdata[0] : 1'b0};
			end
		end
	endgenerate
	// software may clear the log by writing zero; a trip in that cycle wins
	assign log_clear = |(wr_status & ~{THREADS{1'b0}}) &&
		!msr_req_in[0].wdata[STAT_LOG_BIT] && wr_status[0] ||
		(THREADS > 1 && wr_status[THREADS-1] && !msr_req_in[THREADS-1].wdata[STAT_LOG_BIT]);
	// merged thread duty: lowest normally, highest on the legacy option
	always_comb
	begin
		gate_slots = 4'hf;
		if (LEGACY_HIGHEST)
			gate_slots = 4'h0;
		for (int i = 0; i < THREADS; i++)
		begin
			if (LEGACY_HIGHEST && thread_slots[i] > gate_slots)
				gate_slots = thread_slots[i];
			else if (!LEGACY_HIGHEST && thread_slots[i] < gate_slots)
				gate_slots = thread_slots[i];
		end
		// reserved code zero falls back to the default eighth
		if (gate_slots == 4'h0)
			gate_slots = {DUTY_CODE_RESERVED + 3'h1, 1'b0};
		// throttle duty overrides the software duty while hot, unless frequency/voltage throttling is also on
		if (throttle_duty_on)
			gate_slots = THROTTLE_DUTY_SLOTS;
	end
	// modulation needs all threads enabled; duty field ignored otherwise
	assign sw_mod_on = &thread_on;
	assign throttle_duty_on = duty_throttle_en_reg && tcc_engaged && !fv_throttle_en_reg;
	stop_clock_gate #(
		.SLOT_W(4)
	) u_gate (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.active_in(sw_mod_on || throttle_duty_on),
		.ext_mode_in(1'b1),
		.pass_slots_in(gate_slots),
		.clk_pass_out(gate_pass),
		.window_end_out(gate_window_end)
	);
	assign core_clk_en_out = gate_pass;
	// frequency/voltage throttling with its target; adaptive low point is selected only in TCC_HYST, where no target is applied
	assign fv_engaged = fv_throttle_en_reg && tcc_engaged;
	assign fv_target = (adaptive_en_in && state_reg == TCC_HYST && last_target_reg == throttle_target_in) ?
		adaptive_low_target_in : throttle_target_in;
	// interrupts stay pending through gated-off slots; the source keeps them, so none is lost
	assign irq_hold = !gate_pass && !gate_window_end;
	assign irq_deliver_out = irq_pending_in && gate_pass && !irq_hold;
	assign thermal_irq_out = ((rise_evt && int_en_reg[INT_HIGH_EN_BIT]) ||
		(fall_evt && int_en_reg[INT_LOW_EN_BIT])) && !lvt_mask_in;
	assign perf_apply_out.valid = perf_valid_reg;
	assign perf_apply_out.target = perf_target_reg;
	assign tsc_out = tsc_reg;
	// core-wide state, thermal log and throttle engine
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			state_reg <= TCC_IDLE;
			hold_cnt_reg <= '0;
			log_reg <= 1'b0;
			trip_prev_reg <= 1'b0;
			int_en_reg <= INT_CTRL_RESET;
			duty_throttle_en_reg <= 1'b0;
			fv_throttle_en_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			hold_cnt_reg <= hold_cnt_next;
			trip_prev_reg <= sensor_trip_in;
			if (sensor_trip_in)
				log_reg <= 1'b1;
			else if (log_clear)
				log_reg <= 1'b0;
			for (int i = 0; i < THREADS; i++)
			begin
				if (wr_int[i])
					int_en_reg <= msr_req_in[i].wdata[1:0];
				if (wr_misc[i])
				begin
					duty_throttle_en_reg <= msr_req_in[i].wdata[MISC_DUTY_THROTTLE_BIT];
					fv_throttle_en_reg <= msr_req_in[i].wdata[MISC_FV_THROTTLE_BIT];
				end
			end
		end
	end
	// performance requests: pass in duty mode, defer in frequency/voltage mode
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			perf_held_reg <= 1'b0;
			perf_held_target_reg <= '0;
			perf_valid_reg <= 1'b0;
			perf_target_reg <= '0;
			last_target_reg <= '0;
		end
		else
		begin
			perf_valid_reg <= 1'b0;
			if (fv_engaged && (state_reg == TCC_MIN_HOLD) && hold_cnt_reg == '0)
			begin
				perf_valid_reg <= 1'b1;
				perf_target_reg <= fv_target;
				last_target_reg <= fv_target;
			end
			else if (perf_req_in.valid && fv_engaged)
			begin
				perf_held_reg <= 1'b1;
				perf_held_target_reg <= perf_req_in.target;
			end
			else if (perf_req_in.valid)
			begin
				perf_valid_reg <= 1'b1;
				perf_target_reg <= perf_req_in.target;
				perf_held_reg <= 1'b0;
			end
			else if (perf_held_reg && !fv_engaged)
			begin
				perf_valid_reg <= 1'b1;
				perf_target_reg <= perf_held_target_reg;
				perf_held_reg <= 1'b0;
			end
		end
	end
	// time-stamp counter counts every unmodulated clock
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			tsc_reg <= '0;
		else
			tsc_reg <= tsc_reg + 64'h0000_0000_0000_0001;
	end
endmodule : thermal_throttle_clock_modulation
`default_nettype wire

// >>> test/thermal_throttle_props.sv
// checker: port-level properties of the thermal throttle block
`timescale 1ns/1ps
`default_nettype none
module thermal_throttle_props
	import thermal_throttle_pkg::*;
#(
	parameter int unsigned THREADS = 2
)
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire msr_req_t [THREADS-1:0] msr_req_in,
	input wire logic [THREADS-1:0][63:0] msr_rdata_out,
	input wire logic sensor_trip_in,
	input wire logic adaptive_en_in,
	input wire perf_req_t perf_req_in,
	input wire logic irq_pending_in,
	input wire logic irq_deliver_out,
	input wire logic thermal_irq_out,
	input wire logic core_clk_en_out,
	input wire logic adaptive_peer_req_out,
	input wire perf_req_t perf_apply_out,
	input wire logic [63:0] tsc_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// thread 0 looks at the status word
	wire logic rd_stat = msr_req_in[0].addr == ADDR_THERMAL_STATUS;
	wire logic no_wr = !msr_req_in[0].wr && !msr_req_in[THREADS-1].wr;
	a_tsc_every_clk: assert property (!$past(reset_in) |-> tsc_out == $past(tsc_out) + 64'h1)
		else $error("tsc did not advance by one");
	a_status_needs_trip: assert property ((rd_stat && msr_rdata_out[0][STAT_CUR_BIT]) |-> sensor_trip_in)
		else $error("status set while sensor cool");
	a_log_stays_set: assert property (($past(rd_stat && msr_rdata_out[0][STAT_LOG_BIT]) && $past(no_wr)
		&& rd_stat && !$past(reset_in)) |-> msr_rdata_out[0][STAT_LOG_BIT])
		else $error("trip log lost without a clear");
	a_irq_on_edge: assert property ((thermal_irq_out && !$past(reset_in)) |-> sensor_trip_in != $past(sensor_trip_in))
		else $error("thermal irq without a sensor edge");
	a_irq_held_gated: assert property (irq_deliver_out == (irq_pending_in && core_clk_en_out))
		else $error("interrupt delivery not tied to clock gate");
	a_adapt_peer_req: assert property (adaptive_peer_req_out == (adaptive_en_in && sensor_trip_in))
		else $error("peer request mismatch");
	a_apply_one_cycle: assert property ((perf_apply_out.valid && !perf_req_in.valid) |=> !perf_apply_out.valid)
		else $error("perf apply longer than one cycle");
	a_duty_write_read: assert property ((msr_req_in[0].wr && msr_req_in[0].addr == ADDR_CLOCK_DUTY_CTRL
		##1 msr_req_in[0].addr == ADDR_CLOCK_DUTY_CTRL) |-> msr_rdata_out[0][4:0] == $past(msr_req_in[0].wdata[4:0]))
		else $error("duty control not written");
	a_int_en_reset: assert property (($past(reset_in) && msr_req_in[0].addr == ADDR_THERMAL_INT_CTRL)
		|-> msr_rdata_out[0][1:0] == INT_CTRL_RESET)
		else $error("interrupt enables not clear after reset");
	c_irq: cover property (thermal_irq_out);
	c_apply: cover property (perf_apply_out.valid);
	c_held: cover property (irq_pending_in && !core_clk_en_out);
endmodule : thermal_throttle_props
bind thermal_throttle_clock_modulation thermal_throttle_props #(.THREADS(THREADS)) u_props (.*);
`default_nettype wire

// >>> test/thermal_throttle_clock_modulation_bench.sv
// self-checking bench for the thermal throttle and clock modulation block
`timescale 1ns/1ps
`default_nettype none
module thermal_throttle_clock_modulation_bench;
	import thermal_throttle_pkg::*;
	localparam int unsigned ME = 8;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	msr_req_t [1:0] req = {2{msr_req_t'{1'b0, ADDR_THERMAL_INT_CTRL, 64'h0}}};
	logic [1:0][63:0] rdata;
	logic trip = 1'b0;
	logic cool = 1'b1;
	logic aen = 1'b0;
	logic pend = 1'b0;
	perf_req_t perf = '0;
	perf_req_t apply;
	logic irq_dl, irq, clk_en, peer_req;
	logic [63:0] tsc, t0;
	int failures = 0;
	int samples_checked = 0;
	int irqs = 0;
	int n;
	int cyc = 0;
	int c0;
	thermal_throttle_clock_modulation #(.MIN_ENGAGE(ME)) u_dut (
		.clk_in(clk_in), .reset_in(reset_in), .msr_req_in(req), .msr_rdata_out(rdata),
		.sensor_trip_in(trip), .sensor_cool_in(cool), .peer_core_trip_in(1'b0),
		.adaptive_en_in(aen), .throttle_target_in(16'h0f0f), .adaptive_low_target_in(16'h0303),
		.perf_req_in(perf), .lvt_mask_in(1'b0), .irq_pending_in(pend), .irq_deliver_out(irq_dl),
		.thermal_irq_out(irq), .core_clk_en_out(clk_en), .adaptive_peer_req_out(peer_req),
		.perf_apply_out(apply), .tsc_out(tsc));
	// free-running clock and a tally of thermal interrupt pulses
	initial
	begin
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) if (irq === 1'b1) irqs <= irqs + 1;
	// bench-side cycle count, independent of the time-stamp counter
	always @(posedge clk_in) cyc <= cyc + 1;
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input int t, input logic [1:0] a, input logic [63:0] d);
		@(posedge clk_in);
		req[t] <= '{1'b1, a, d};
		@(posedge clk_in);
		req[t].wr <= 1'b0;
	endtask : wr
	// read data is combinational, so look just after the address settles
	task automatic rdchk(input logic [1:0] a, input logic [63:0] e);
		@(posedge clk_in);
		req[0].addr <= a;
		#1 chk(rdata[0], e);
	endtask : rdchk
	// any 16 consecutive cycles span one whole window, whatever its phase
	task automatic duty(input logic [4:0] d0, input logic [4:0] d1, input logic [7:0] e);
		logic [7:0] c;
		logic [7:0] g;
		wr(0, ADDR_CLOCK_DUTY_CTRL, 64'(d0));
		wr(1, ADDR_CLOCK_DUTY_CTRL, 64'(d1));
		repeat (32) @(posedge clk_in);
		c = 8'h0;
		g = 8'h0;
		repeat (16)
		begin
			@(posedge clk_in);
			#1 c = c + {7'h0, clk_en};
			g = g + {7'h0, irq_dl};
		end
		chk(64'(c), 64'(e));
		chk(64'(g), 64'(e));
	endtask : duty
	task automatic preq(input logic [15:0] t);
		@(posedge clk_in);
		perf <= '{1'b1, t};
		@(posedge clk_in);
		perf.valid <= 1'b0;
	endtask : preq
	// bounded wait for the applied performance pulse
	task automatic wapp(output int c);
		c = 0;
		#1;
		while (apply.valid !== 1'b1 && c < 60)
		begin
			@(posedge clk_in);
			#1 c++;
		end
	endtask : wapp
	task automatic report_and_stop();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	initial
	begin
		#200us;
		failures++;
		report_and_stop();
	end
	initial
	begin
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		rdchk(ADDR_THERMAL_INT_CTRL, 64'h0);
		rdchk(ADDR_THERMAL_STATUS, 64'h0);
		rdchk(ADDR_CLOCK_DUTY_CTRL, 64'(CLOCK_DUTY_RESET));
		rdchk(ADDR_MISC_FEATURE_EN, 64'h0);
		@(posedge clk_in);
		pend <= 1'b1;
		@(posedge clk_in);
		#1 t0 = tsc;
		c0 = cyc;
		for (int c = 0; c < 8; c++)
			duty(5'(16 + 2 * c), 5'(16 + 2 * c), 8'(c == 0 ? 2 : 2 * c));
		duty(5'h13, 5'h13, 8'h03);
		duty(5'h14, 5'h1c, 8'h04);
		duty(5'h1c, 5'h0c, 8'h10);
		duty(5'h0e, 5'h0e, 8'h10);
		@(posedge clk_in);
		#1 chk(tsc - t0, 64'(cyc - c0));
		// duty-cycle throttling: trip, override, early perf change, both irq edges
		wr(0, ADDR_MISC_FEATURE_EN, 64'h0008);
		wr(0, ADDR_THERMAL_INT_CTRL, 64'h0003);
		n = irqs;
		trip <= 1'b1;
		aen <= 1'b1;
		cool <= 1'b0;
		rdchk(ADDR_THERMAL_STATUS, 64'h0003);
		chk(64'(irqs - n), 64'h1);
		chk(64'(peer_req), 64'h1);
		duty(5'h12, 5'h12, 8'h08);
		preq(16'h1234);
		wapp(n);
		chk(64'(n), 64'h0);
		chk(64'(apply.target), 64'h1234);
		@(posedge clk_in);
		n = irqs;
		trip <= 1'b0;
		cool <= 1'b1;
		aen <= 1'b0;
		rdchk(ADDR_THERMAL_STATUS, 64'h0002);
		chk(64'(irqs - n), 64'h1);
		wr(0, ADDR_THERMAL_STATUS, 64'h0);
		rdchk(ADDR_THERMAL_STATUS, 64'h0);
		wr(0, ADDR_THERMAL_INT_CTRL, 64'h0);
		n = irqs;
		trip <= 1'b1;
		repeat (3) @(posedge clk_in);
		trip <= 1'b0;
		repeat (3 * ME) @(posedge clk_in);
		chk(64'(irqs - n), 64'h0);
		// frequency/voltage throttling: minimum hold, hysteresis, held perf change
		wr(0, ADDR_MISC_FEATURE_EN, 64'h2000);
		repeat (3 * ME) @(posedge clk_in);
		trip <= 1'b1;
		@(posedge clk_in);
		trip <= 1'b0;
		preq(16'h00a5);
		wapp(n);
		chk(64'(n >= ME / 2), 64'h1);
		@(posedge clk_in);
		cool <= 1'b0;
		trip <= 1'b1;
		n = 0;
		repeat (4)
		begin
			@(posedge clk_in);
			#1;
			if (apply.valid === 1'b1)
			begin
				n++;
				chk(64'(apply.target), 64'h0f0f);
			end
		end
		chk(64'(n), 64'h1);
		@(posedge clk_in);
		trip <= 1'b0;
		preq(16'h005a);
		n = 0;
		repeat (20)
		begin
			@(posedge clk_in);
			#1 n += (apply.valid === 1'b1);
		end
		chk(64'(n), 64'h0);
		@(posedge clk_in);
		cool <= 1'b1;
		wapp(n);
		chk({48'h0, apply.target}, 64'h005a);
		report_and_stop();
	end
endmodule : thermal_throttle_clock_modulation_bench
`default_nettype wire
